// [hdl/pdag_regs.svh]
// constants of the paged data address generator
`ifndef PDAG_REGS_SVH
`define PDAG_REGS_SVH

// ==========================================================
// widths
`define PDAG_PAGE_W 10
`define PDAG_ADDR_W 16
`define PDAG_WIN_BIT 15

// ==========================================================
// page codes at space boundaries
`define PDAG_PG_ZERO 10'h000
`define PDAG_PG_FIRST 10'h001
`define PDAG_PG_XDS_LAST 10'h1ff
`define PDAG_PG_LSW_FIRST 10'h200
`define PDAG_PG_LSW_LAST 10'h2ff
`define PDAG_PG_MSB_FIRST 10'h300
`define PDAG_PG_MSB_LAST 10'h3ff
`define PDAG_PG_PROG_BIT 9

// ==========================================================
// reset values
`define PDAG_RD_PAGE_RST 10'h001
`define PDAG_WR_PAGE_RST 10'h001

`endif

// [hdl/pdag_pkg.sv]
// types of the paged data address generator
package pdag_pkg;
   // addressing mode of one access
   typedef enum logic [2:0] {
      AM_PLAIN,
      AM_PRE,
      AM_POST,
      AM_OFFSET,
      AM_MODULO,
      AM_BITREV
   } pdag_mode_t;

   typedef logic [9:0] pdag_page_t;
   typedef logic [15:0] pdag_addr_t;
endpackage : pdag_pkg

// [hdl/pdag_calc_if.sv]
// carrier between the page register file and the address calculator
`timescale 1ns/10ps
interface pdag_calc_if;
   import pdag_pkg::*;
   pdag_page_t selected_data_page;
   pdag_addr_t base_addr;
   pdag_addr_t delta;
   pdag_mode_t mode;
   logic is_write;
   pdag_page_t next_page;
   pdag_addr_t access_addr;
   pdag_addr_t pointer_addr;
   logic ovf;
   logic unf;
   logic addr_err;

   modport owner (
      output selected_data_page, base_addr, delta, mode, is_write,
      input next_page, access_addr, pointer_addr, ovf, unf, addr_err
   );
   modport calc (
      input selected_data_page, base_addr, delta, mode, is_write,
      output next_page, access_addr, pointer_addr, ovf, unf, addr_err
   );
endinterface : pdag_calc_if

// [hdl/pdag_calc.sv]
// combinational effective address and page correction
`timescale 1ns/10ps
`include "pdag_regs.svh"
module pdag_calc
   import pdag_pkg::*;
(
   // request and result
   pdag_calc_if.calc c
);
   logic [15:0] sum;
   logic [15:0] delta_eff;
   logic paged;
   logic crossed;
   logic walk;
   logic wrapm;
   pdag_addr_t mod_addr;
   pdag_page_t pg;

   // ==========================================================
   // modification and boundary detection
   always_comb begin
      pg = c.selected_data_page;
      walk = (c.mode == AM_PRE) || (c.mode == AM_POST);
      wrapm = (c.mode == AM_OFFSET) || (c.mode == AM_MODULO) || (c.mode == AM_BITREV);
      delta_eff = (c.mode == AM_PLAIN) ? 16'h0000 : c.delta;
      sum = {1'b0, c.base_addr[14:0]} + delta_eff;
      paged = c.base_addr[`PDAG_WIN_BIT] && (pg != `PDAG_PG_ZERO);
      crossed = paged && sum[15] && (walk || wrapm);
      c.ovf = crossed && !delta_eff[15];
      c.unf = crossed && delta_eff[15];
      c.next_page = pg;
      mod_addr = {1'b0, sum[14:0]};
      if (!crossed) begin
         if (c.base_addr[`PDAG_WIN_BIT]) begin
            mod_addr = {1'b1, sum[14:0]};
         end else begin
            mod_addr = c.base_addr + delta_eff;
         end
      end else if (wrapm) begin
         mod_addr[`PDAG_WIN_BIT] = 1'b1;
      end else if (c.ovf) begin
         if (pg == `PDAG_PG_XDS_LAST || pg == `PDAG_PG_MSB_LAST) begin
            mod_addr[`PDAG_WIN_BIT] = 1'b0;
         end else if (!c.is_write && pg == `PDAG_PG_LSW_LAST) begin
            c.next_page = `PDAG_PG_MSB_FIRST;
            mod_addr[`PDAG_WIN_BIT] = 1'b1;
         end else begin
            c.next_page = pg + 10'h001;
            mod_addr[`PDAG_WIN_BIT] = 1'b1;
         end
      end else begin
         if (pg == `PDAG_PG_FIRST || pg == `PDAG_PG_LSW_FIRST) begin
            mod_addr[`PDAG_WIN_BIT] = 1'b0;
         end else if (!c.is_write && pg == `PDAG_PG_MSB_FIRST) begin
            c.next_page = `PDAG_PG_LSW_LAST;
            mod_addr[`PDAG_WIN_BIT] = 1'b1;
         end else begin
            c.next_page = pg - 10'h001;
            mod_addr[`PDAG_WIN_BIT] = 1'b1;
         end
      end
      // pre-modified and offset forms use the new address for the access
      if (c.mode == AM_PRE || c.mode == AM_OFFSET) begin
         c.access_addr = mod_addr;
      end else begin
         c.access_addr = c.base_addr;
      end
      // offset form leaves the pointer untouched
      if (c.mode == AM_OFFSET || c.mode == AM_PLAIN) begin
         c.pointer_addr = c.base_addr;
      end else begin
         c.pointer_addr = mod_addr;
      end
      c.addr_err = (c.base_addr[`PDAG_WIN_BIT] && pg == `PDAG_PG_ZERO)
         || (c.is_write && c.base_addr[`PDAG_WIN_BIT] && pg[`PDAG_PG_PROG_BIT]);
   end
endmodule : pdag_calc

// [hdl/pdag_top.sv]
// paged data address generator: page registers, access pipeline, checks
// Function
// - separate read and write page registers
// - page crossing clears address bit 15 first
// - crossing counts for every modified (non-plain) paged access
// - overflow increments page and sets bit 15
// - underflow decrements page and sets bit 15
// - offset/modulo/bit-reverse wrap within current page
// - read overflow at page 1FF keeps, clears bit
// - write overflow at page 1FF keeps, clears bit
// - read overflow 2FF advances to 300, bit set
// - read overflow at 3FF keeps, clears bit
// - read underflow at 001 or 200 keeps, clears
// - read underflow 300 steps to 2FF, bit set
// - cleared bit 15 lands in base space
// - paged access with page zero raises error
// - writing program space through write page errors
`timescale 1ns/10ps
`include "pdag_regs.svh"
module pdag_top
   import pdag_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // page register load
   input wire logic page_load,
   input wire logic page_load_write,
   input wire pdag_page_t page_load_val,
   // access request
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire pdag_mode_t acc_mode,
   input wire pdag_addr_t acc_addr,
   input wire pdag_addr_t acc_delta,
   // access result
   output logic out_valid_q,
   output pdag_addr_t effective_address_q,
   output pdag_page_t out_page_q,
   output pdag_addr_t pointer_addr_q,
   output logic extended_data_space_q,
   output logic program_space_window_q,
   output logic addr_err_q,
   // page registers
   output pdag_page_t data_read_page_q,
   output pdag_page_t data_write_page_q
);
   pdag_calc_if ci ();

   pdag_page_t data_read_page_d;
   pdag_page_t data_write_page_d;
   pdag_page_t selected_data_page;
   logic out_valid_d;
   pdag_addr_t effective_address_d;
   pdag_page_t out_page_d;
   pdag_addr_t pointer_addr_d;
   logic extended_data_space_d;
   logic program_space_window_d;
   logic addr_err_d;
   logic fire;

   // ==========================================================
   // calculator hookup
   assign selected_data_page = acc_write ? data_write_page_q : data_read_page_q;
   assign ci.selected_data_page = selected_data_page;
   assign ci.base_addr = acc_addr;
   assign ci.delta = acc_delta;
   assign ci.mode = acc_mode;
   assign ci.is_write = acc_write;
   assign fire = ce && acc_valid;

   pdag_calc u_calc (
      .c(ci.calc)
   );

   // ==========================================================
   // page registers
   always_comb begin
      data_read_page_d = data_read_page_q;
      data_write_page_d = data_write_page_q;
      if (page_load) begin
         if (page_load_write) begin
            data_write_page_d = page_load_val;
         end else begin
            data_read_page_d = page_load_val;
         end
      end
      // a page step by an access beats a load in the same cycle
      if (acc_valid && !ci.addr_err) begin
         if (acc_write) begin
            data_write_page_d = ci.next_page;
         end else begin
            data_read_page_d = ci.next_page;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         data_read_page_q <= `PDAG_RD_PAGE_RST;
         data_write_page_q <= `PDAG_WR_PAGE_RST;
      end else if (ce) begin
         data_read_page_q <= data_read_page_d;
         data_write_page_q <= data_write_page_d;
      end
   end

   // ==========================================================
   // access result
   always_comb begin
      out_valid_d = acc_valid;
      effective_address_d = effective_address_q;
      out_page_d = out_page_q;
      pointer_addr_d = pointer_addr_q;
      extended_data_space_d = extended_data_space_q;
      program_space_window_d = program_space_window_q;
      addr_err_d = 1'b0;
      if (acc_valid) begin
         effective_address_d = ci.access_addr;
         pointer_addr_d = ci.pointer_addr;
         out_page_d = selected_data_page;
         // page of the access itself; post form uses the old page
         if (acc_mode == AM_PRE) begin
            out_page_d = ci.next_page;
         end
         extended_data_space_d = ci.access_addr[`PDAG_WIN_BIT]
            && !out_page_d[`PDAG_PG_PROG_BIT];
         program_space_window_d = ci.access_addr[`PDAG_WIN_BIT]
            && out_page_d[`PDAG_PG_PROG_BIT];
         addr_err_d = ci.addr_err;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         out_valid_q <= 1'b0;
         effective_address_q <= 16'h0000;
         out_page_q <= 10'h000;
         pointer_addr_q <= 16'h0000;
         extended_data_space_q <= 1'b0;
         program_space_window_q <= 1'b0;
         addr_err_q <= 1'b0;
      end else if (ce) begin
         out_valid_q <= out_valid_d;
         effective_address_q <= effective_address_d;
         out_page_q <= out_page_d;
         pointer_addr_q <= pointer_addr_d;
         extended_data_space_q <= extended_data_space_d;
         program_space_window_q <= program_space_window_d;
         addr_err_q <= addr_err_d;
      end
   end

   // ==========================================================
   // checks
   chk_read_write_split: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_write && !page_load |=> data_read_page_q == $past(data_read_page_q))
      else $error("read page moved on a write access");

   chk_raw_clear: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_mode == AM_POST && ci.ovf && !acc_write
      && data_read_page_q == `PDAG_PG_XDS_LAST
      |=> !pointer_addr_q[15]
      && pointer_addr_q[14:0] == 15'($past(acc_addr) + $past(acc_delta)))
      else $error("raw crossing result wrong");

   chk_offset_nowalk: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_mode == AM_OFFSET && !page_load && !acc_write
      |=> data_read_page_q == $past(data_read_page_q))
      else $error("offset access moved the page");

   chk_ovf_general: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.ovf && acc_mode == AM_PRE
      && data_read_page_q < `PDAG_PG_XDS_LAST && !ci.addr_err
      |=> data_read_page_q == $past(data_read_page_q) + 10'h001 && pointer_addr_q[15])
      else $error("overflow did not step page up");

   chk_unf_general: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_write && ci.unf && acc_mode == AM_POST
      && data_write_page_q > `PDAG_PG_FIRST && !ci.addr_err
      |=> data_write_page_q == $past(data_write_page_q) - 10'h001 && pointer_addr_q[15])
      else $error("underflow did not step page down");

   chk_wrap_modes: assert property (@(posedge mclk) disable iff (rst)
      fire && (acc_mode == AM_MODULO || acc_mode == AM_BITREV) && (ci.ovf || ci.unf)
      && !acc_write && !page_load
      |=> pointer_addr_q[15] && data_read_page_q == $past(data_read_page_q))
      else $error("wrap mode changed page or bit");

   chk_read_xds_end: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.ovf && acc_mode == AM_POST
      && data_read_page_q == `PDAG_PG_XDS_LAST
      |=> data_read_page_q == `PDAG_PG_XDS_LAST && !pointer_addr_q[15])
      else $error("read overflow at last extended page");

   chk_write_xds_end: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_write && ci.ovf && acc_mode == AM_PRE
      && data_write_page_q == `PDAG_PG_XDS_LAST
      |=> data_write_page_q == `PDAG_PG_XDS_LAST && !effective_address_q[15])
      else $error("write overflow at last extended page");

   chk_lsw_to_msb: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.ovf && acc_mode == AM_PRE
      && data_read_page_q == `PDAG_PG_LSW_LAST
      |=> data_read_page_q == `PDAG_PG_MSB_FIRST && program_space_window_q
      && out_page_q == `PDAG_PG_MSB_FIRST)
      else $error("lsw to msb step wrong");

   chk_msb_end: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.ovf && acc_mode == AM_POST
      && data_read_page_q == `PDAG_PG_MSB_LAST
      |=> data_read_page_q == `PDAG_PG_MSB_LAST && !pointer_addr_q[15])
      else $error("read overflow at last msb page");

   chk_unf_first: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.unf && acc_mode == AM_PRE
      && (data_read_page_q == `PDAG_PG_FIRST || data_read_page_q == `PDAG_PG_LSW_FIRST)
      |=> data_read_page_q == $past(data_read_page_q) && !effective_address_q[15]
      && !extended_data_space_q && !program_space_window_q)
      else $error("underflow at first page wrong");

   chk_msb_to_lsw: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.unf && acc_mode == AM_POST
      && data_read_page_q == `PDAG_PG_MSB_FIRST
      |=> data_read_page_q == `PDAG_PG_LSW_LAST && pointer_addr_q[15])
      else $error("msb to lsw step wrong");

   chk_page_zero_err: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_addr[15] && selected_data_page == `PDAG_PG_ZERO
      |=> addr_err_q && out_valid_q ##1 (!addr_err_q || $past(fire) || !$past(ce)))
      else $error("page zero access not flagged");

   chk_prog_write_err: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_write && acc_addr[15] && data_write_page_q[9] && !page_load
      |=> addr_err_q && data_write_page_q == $past(data_write_page_q))
      else $error("program space write not flagged");

   chk_carry_source: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_addr[15] && selected_data_page != `PDAG_PG_ZERO && acc_mode == AM_POST
      && !acc_delta[15] && ({1'b0, acc_addr[14:0]} + acc_delta) < 16'h8000 |-> !ci.ovf)
      else $error("crossing without carry");

   chk_freeze: assert property (@(posedge mclk) disable iff (rst)
      !ce |=> $stable(data_read_page_q) && $stable(data_write_page_q) && $stable(out_valid_q))
      else $error("state moved with enable low");

   chk_write_page_hold: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && !page_load |=> data_write_page_q == $past(data_write_page_q))
      else $error("write page moved on a read access");

   chk_post_read_page: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && acc_mode == AM_POST |=> out_page_q == $past(data_read_page_q))
      else $error("read access did not use the read page");

   chk_post_write_page: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_write && acc_mode == AM_POST |=> out_page_q == $past(data_write_page_q))
      else $error("write access did not use the write page");

   chk_raw_clear_pre: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_mode == AM_PRE && ci.ovf && !acc_write
      && data_read_page_q == `PDAG_PG_MSB_LAST
      |=> !effective_address_q[15]
      && effective_address_q[14:0] == 15'($past(acc_addr) + $past(acc_delta)))
      else $error("raw crossing address wrong");

   chk_offset_wrap: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_mode == AM_OFFSET && (ci.ovf || ci.unf)
      |=> effective_address_q[15] && pointer_addr_q == $past(acc_addr))
      else $error("offset crossing did not wrap");

   chk_ovf_write_step: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_write && ci.ovf && acc_mode == AM_POST
      && data_write_page_q < `PDAG_PG_XDS_LAST && !ci.addr_err
      |=> data_write_page_q == $past(data_write_page_q) + 10'h001 && pointer_addr_q[15])
      else $error("write overflow did not step page up");

   chk_unf_read_step: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.unf && acc_mode == AM_PRE
      && data_read_page_q > `PDAG_PG_FIRST && data_read_page_q < `PDAG_PG_LSW_FIRST
      |=> data_read_page_q == $past(data_read_page_q) - 10'h001 && effective_address_q[15])
      else $error("read underflow did not step page down");

   chk_lsw_msb_post: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.ovf && acc_mode == AM_POST
      && data_read_page_q == `PDAG_PG_LSW_LAST
      |=> data_read_page_q == `PDAG_PG_MSB_FIRST && pointer_addr_q[15]
      && out_page_q == `PDAG_PG_LSW_LAST)
      else $error("post increment lsw to msb step wrong");

   chk_unf_first_post: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.unf && acc_mode == AM_POST
      && (data_read_page_q == `PDAG_PG_FIRST || data_read_page_q == `PDAG_PG_LSW_FIRST)
      |=> data_read_page_q == $past(data_read_page_q) && !pointer_addr_q[15])
      else $error("post decrement at first page wrong");

   chk_msb_lsw_pre: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.unf && acc_mode == AM_PRE
      && data_read_page_q == `PDAG_PG_MSB_FIRST
      |=> data_read_page_q == `PDAG_PG_LSW_LAST && effective_address_q[15]
      && out_page_q == `PDAG_PG_LSW_LAST)
      else $error("pre decrement msb to lsw step wrong");

   chk_base_space: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && ci.ovf && acc_mode == AM_PRE
      && (data_read_page_q == `PDAG_PG_XDS_LAST || data_read_page_q == `PDAG_PG_MSB_LAST)
      |=> !extended_data_space_q && !program_space_window_q)
      else $error("cleared bit 15 left the base space");

   chk_page_zero_hold: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_addr[15] && selected_data_page == `PDAG_PG_ZERO && !page_load
      |=> data_read_page_q == $past(data_read_page_q)
      && data_write_page_q == $past(data_write_page_q))
      else $error("page zero access moved a page");

   chk_prog_read_ok: assert property (@(posedge mclk) disable iff (rst)
      fire && !acc_write && acc_addr[15] && data_read_page_q[`PDAG_PG_PROG_BIT]
      && acc_mode == AM_POST |=> !addr_err_q && program_space_window_q)
      else $error("program space read trapped");

   chk_carry_set: assert property (@(posedge mclk) disable iff (rst)
      fire && acc_addr[15] && selected_data_page != `PDAG_PG_ZERO && acc_mode == AM_PRE
      && !acc_delta[15] && ({1'b0, acc_addr[14:0]} + acc_delta) > 16'h7fff |-> ci.ovf)
      else $error("carry without crossing");

   chk_valid_follow: assert property (@(posedge mclk) disable iff (rst)
      fire |=> out_valid_q)
      else $error("accepted access gave no result");

   chk_idle_quiet: assert property (@(posedge mclk) disable iff (rst)
      ce && !acc_valid |=> !out_valid_q && !addr_err_q)
      else $error("result shown without an access");
endmodule : pdag_top

// [tb/pdag_bus_model.sv]
// memory bus side of the address generator: takes each completed access
`timescale 1ns/10ps
module pdag_bus_model
   import pdag_pkg::*;
(
   // clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // access from the generator
   input wire logic out_valid_q,
   input wire logic addr_err_q,
   // count of accesses that reached memory
   output int taken
);
   // ==========================================================
   // trapped accesses never reach memory
   always_ff @(posedge mclk) begin
      if (rst) begin
         taken <= 0;
      // a frozen cycle shows the same access again, so count only live edges
      end else if (ce && out_valid_q && !addr_err_q) begin
         taken <= taken + 1;
      end
   end
endmodule : pdag_bus_model

// [tb/pdag_top_tb_top.sv]
// self-checking testbench of the paged data address generator
`timescale 1ns/10ps
module pdag_top_tb_top;
   import pdag_pkg::*;
   // ==========================================================
   // signals and model state
   logic mclk, rst, ce, page_load, page_load_write, acc_valid, acc_write, nrst;
   logic out_valid_q, extended_data_space_q, program_space_window_q, addr_err_q;
   pdag_page_t page_load_val, out_page_q, data_read_page_q, data_write_page_q;
   pdag_mode_t acc_mode;
   pdag_addr_t acc_addr, acc_delta, effective_address_q, pointer_addr_q;
   int errors, n_compared, n_ok, taken, rp, wp;
   int cycles = 0;
   logic ev, ee, eeds, epsv, cmp_a, cmp_f;
   logic [15:0] ea, ept;
   logic [9:0] epg;
   localparam logic [45:0] TBL [26] = '{
      {1'h0, AM_PRE, 10'h1ff, 32'hffff0001}, {1'h1, AM_POST, 10'h1ff, 32'hffff0002},
      {1'h0, AM_PRE, 10'h2ff, 32'hffff0001}, {1'h0, AM_POST, 10'h3ff, 32'hfffe0002},
      {1'h0, AM_PRE, 10'h001, 32'h8000ffff}, {1'h0, AM_POST, 10'h200, 32'h8000fffe},
      {1'h0, AM_PRE, 10'h300, 32'h8001fffe}, {1'h0, AM_POST, 10'h005, 32'hffff0001},
      {1'h1, AM_PRE, 10'h105, 32'h8000ffff}, {1'h0, AM_OFFSET, 10'h005, 32'hffff0001},
      {1'h0, AM_MODULO, 10'h005, 32'h8000ffff}, {1'h0, AM_BITREV, 10'h1ff, 32'hffff0004},
      {1'h0, AM_PLAIN, 10'h005, 32'hffff0001}, {1'h0, AM_PRE, 10'h005, 32'h7fff0001},
      {1'h0, AM_PRE, 10'h000, 32'h80000000}, {1'h1, AM_POST, 10'h250, 32'h90000001},
      {1'h1, AM_PRE, 10'h001, 32'h8000ffff}, {1'h0, AM_POST, 10'h1ff, 32'hffff0001},
      {1'h1, AM_PRE, 10'h1ff, 32'hffff0001}, {1'h0, AM_POST, 10'h300, 32'h8000ffff},
      {1'h1, AM_POST, 10'h105, 32'h8000ffff}, {1'h0, AM_PRE, 10'h005, 32'hffff0001},
      {1'h0, AM_PRE, 10'h3ff, 32'hffff0001}, {1'h0, AM_POST, 10'h2ff, 32'hfffe0004},
      {1'h1, AM_POST, 10'h105, 32'hffff0001}, {1'h0, AM_PRE, 10'h005, 32'h8000ffff}};
   localparam logic [9:0] PGS [8] = '{10'h001, 10'h002, 10'h1fe, 10'h1ff, 10'h200, 10'h2ff,
      10'h300, 10'h3ff};
   localparam logic [15:0] ADS [6] = '{16'h8000, 16'h8001, 16'hfffe, 16'hffff, 16'h7fff, 16'h1234};

   pdag_top uut (.mclk(mclk), .rst(rst), .ce(ce), .page_load(page_load),
      .page_load_write(page_load_write), .page_load_val(page_load_val), .acc_valid(acc_valid),
      .acc_write(acc_write), .acc_mode(acc_mode), .acc_addr(acc_addr), .acc_delta(acc_delta),
      .out_valid_q(out_valid_q), .effective_address_q(effective_address_q),
      .out_page_q(out_page_q), .pointer_addr_q(pointer_addr_q),
      .extended_data_space_q(extended_data_space_q),
      .program_space_window_q(program_space_window_q), .addr_err_q(addr_err_q),
      .data_read_page_q(data_read_page_q), .data_write_page_q(data_write_page_q));
   pdag_bus_model bus (.mclk(mclk), .rst(rst), .ce(ce), .out_valid_q(out_valid_q),
      .addr_err_q(addr_err_q), .taken(taken));

   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end

   // ==========================================================
   // reference model, updated with the inputs sampled at each edge
   task automatic model();
      int pg, np;
      logic [15:0] s, na;
      logic cr;
      if (rst) begin
         {rp, wp, ev, ee, eeds, epsv, cmp_a, cmp_f} = {32'h1, 32'h1, 4'h0, 2'h3};
         {ea, ept, epg} = 42'h0;
         return;
      end
      if (!ce) return;
      // the access sees the page held before this edge, not a load in the same cycle
      pg = acc_write ? wp : rp;
      if (page_load && page_load_write) wp = page_load_val;
      if (page_load && !page_load_write) rp = page_load_val;
      ev = acc_valid;
      ee = 0;
      if (!acc_valid) return;
      ee = acc_addr[15] && (pg == 0 || (acc_write && pg >= 512));
      s = {1'b0, acc_addr[14:0]} + acc_delta;
      cr = acc_addr[15] && pg != 0 && acc_mode != AM_PLAIN && s[15];
      na = (acc_addr[15] && pg != 0) ? {1'b1, s[14:0]} : acc_addr + acc_delta;
      np = pg;
      if (cr && (acc_mode == AM_PRE || acc_mode == AM_POST)) begin
         if (!acc_delta[15] && (pg == 511 || (!acc_write && pg == 1023))) na[15] = 0;
         else if (!acc_delta[15]) np = pg + 1;
         else if (pg == 1 || (!acc_write && pg == 512)) na[15] = 0;
         else np = pg - 1;
      end
      if (!ee && acc_write) wp = np;
      if (!ee && !acc_write) rp = np;
      n_ok += int'(!ee);
      ea = (acc_mode == AM_PRE || acc_mode == AM_OFFSET) ? na : acc_addr;
      epg = 10'(acc_mode == AM_PRE ? np : pg);
      ept = (acc_mode == AM_PLAIN || acc_mode == AM_OFFSET) ? acc_addr : na;
      eeds = ea[15] && epg < 10'h200;
      epsv = ea[15] && epg >= 10'h200;
      cmp_a = !ee;
      cmp_f = !ee;
   endtask : model

   task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic check();
      cmp("out_valid_q", 16'(ev), 16'(out_valid_q));
      cmp("addr_err_q", 16'(ee), 16'(addr_err_q));
      cmp("data_read_page_q", 16'(rp), 16'(data_read_page_q));
      cmp("data_write_page_q", 16'(wp), 16'(data_write_page_q));
      if (cmp_a) begin
         cmp("effective_address_q", ea, effective_address_q);
         cmp("out_page_q", 16'(epg), 16'(out_page_q));
         cmp("pointer_addr_q", ept, pointer_addr_q);
      end
      if (cmp_f) begin
         cmp("extended_data_space_q", 16'(eeds), 16'(extended_data_space_q));
         cmp("program_space_window_q", 16'(epsv), 16'(program_space_window_q));
      end
   endtask : check

   // one clock: model takes the old inputs, new ones go out, results are compared
   task automatic step(input logic v, w, input pdag_mode_t m, input pdag_addr_t a, d,
      input logic ld, lw, input pdag_page_t lv, input logic c);
      @(posedge mclk);
      model();
      rst <= nrst;
      acc_valid <= v;
      acc_write <= w;
      acc_mode <= m;
      acc_addr <= a;
      acc_delta <= d;
      page_load <= ld;
      page_load_write <= lw;
      page_load_val <= lv;
      ce <= c;
      #1 check();
   endtask : step

   task automatic give_verdict();
      if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         give_verdict();
      end
   end

   // ==========================================================
   // scenarios
   initial begin
      logic v;
      {rst, nrst, ce, page_load, page_load_write, acc_valid, acc_write} = 7'h60;
      acc_mode = AM_PLAIN;
      {acc_addr, acc_delta, page_load_val} = 42'h0;
      {errors, n_compared, n_ok} = 96'h0;
      void'($urandom(32'ha18d));
      repeat (2) step(0, 0, AM_PLAIN, 16'h0, 16'h0, 0, 0, 10'h0, 1);
      nrst = 0;
      step(0, 0, AM_PLAIN, 16'h0, 16'h0, 0, 0, 10'h0, 1);
      foreach (TBL[i]) begin
         step(0, 0, AM_PLAIN, 16'h0, 16'h0, 1, TBL[i][45], TBL[i][41:32], 1);
         step(1, TBL[i][45], pdag_mode_t'(TBL[i][44:42]), TBL[i][31:16], TBL[i][15:0],
            0, 0, 10'h0, 1);
      end
      step(0, 0, AM_PLAIN, 16'h0, 16'h0, 1, 0, 10'h2ff, 1);
      step(0, 0, AM_PLAIN, 16'h0, 16'h0, 1, 1, 10'h105, 1);
      step(1, 0, AM_PRE, 16'hffff, 16'h0001, 0, 0, 10'h0, 1);
      step(1, 1, AM_PRE, 16'h8000, 16'hffff, 0, 0, 10'h0, 1);
      repeat (400) begin
         v = 1'($urandom_range(0, 2) != 0);
         step(v, 1'($urandom_range(0, 1)), pdag_mode_t'($urandom_range(0, 5)),
            ADS[$urandom_range(0, 5)], 16'($urandom_range(0, 8)) - 16'h0004,
            1'($urandom_range(0, 3) == 0),
            1'($urandom_range(0, 1)), ($urandom_range(0, 3) == 0) ? 10'($urandom) :
            PGS[$urandom_range(0, 7)], 1'($urandom_range(0, 7) != 0));
      end
      repeat (2) step(0, 0, AM_PLAIN, 16'h0, 16'h0, 0, 0, 10'h0, 1);
      cmp("bus_taken", 16'(n_ok), 16'(taken));
      give_verdict();
   end
endmodule : pdag_top_tb_top
